// file: hw/atcc_timer.sv
// Functional notes
// - In async mode writes go via holding register, land after two oscillator edges
// - Each of five buffered registers owns its holding register
// - Status shows a busy bit per buffered register, clearing on transfer
// - Compare matching is suppressed while counter or compare A writes are pending
// - Async interrupt flags reach the CPU after three cycles plus one tick
// - Compare output changes on the timer tick, not resynchronised
// - CPU reads a counter copy refreshed per oscillator edge and frozen while asleep in async mode, every cycle otherwise
// - Wake starts on the tick after the event, then CPU held four cycles
// - Default source is system clock; async select uses oscillator, frees port
// - Prescaler taps: stop, 1, 8, 32, 64, 128, 256, 1024
// - Writing one to prescaler reset bit clears the prescaler
// - Nonzero output mode overrides port; software sets pin direction
// - Non-PWM modes: 0 off, 1 toggle, 2 clear, 3 set on match
// - Fast PWM: 1 toggle only with wave high bit; 2/3 match and bottom
// - Fast PWM with compare at TOP and mode high bit: act at bottom only
// - Phase correct: 2 clears up-count match, sets down; 3 reverse
// - Phase correct with compare at TOP and mode high bit: act at TOP
// - Oscillator runs only with async select set, and not in power-down and standby
// - Three-bit wave field selects normal, phase correct, CTC, fast PWM
//
// Strobed register access is this design's own decision.
`include "atcc_params.svh"
module atcc_timer (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               reset_in,
   // Register port
   input  wire atcc_pkg::atcc_bus_t bus_in,
   output logic [7:0]              rdata_out,
   // Oscillator pin
   input  wire logic               osc_in_pin_in,
   // Power state
   input  wire logic               sleep_in,
   input  wire logic               deep_sleep_in,
   // Pins and wake
   output atcc_pkg::atcc_pins_t    pins_out,
   output logic                    wake_out,
   output logic                    cpu_halt_out
);
   function automatic logic [7:0] hold_ofs(input int idx);
      case (idx)
         0:       hold_ofs = `ATCC_OFS_CTRL_B;
         1:       hold_ofs = `ATCC_OFS_CTRL_A;
         2:       hold_ofs = `ATCC_OFS_CMP_B;
         3:       hold_ofs = `ATCC_OFS_CMP_A;
         default: hold_ofs = `ATCC_OFS_COUNT;
      endcase
   endfunction : hold_ofs

   function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] p);
      unique case (cs)
         3'h0: tap_hit = 1'b0;
         3'h1: tap_hit = 1'b1;
         3'h2: tap_hit = &p[2:0];
         3'h3: tap_hit = &p[4:0];
         3'h4: tap_hit = &p[5:0];
         3'h5: tap_hit = &p[6:0];
         3'h6: tap_hit = &p[7:0];
         3'h7: tap_hit = &p[9:0];
      endcase
   endfunction : tap_hit

   function automatic atcc_pkg::atcc_kind_t kind_of(input logic [2:0] w);
      unique case (w)
         3'h0:      kind_of = atcc_pkg::ATCC_K_NORMAL;
         3'h1, 3'h5: kind_of = atcc_pkg::ATCC_K_PC;
         3'h2:      kind_of = atcc_pkg::ATCC_K_CTC;
         3'h3, 3'h7: kind_of = atcc_pkg::ATCC_K_FAST;
         default:   kind_of = atcc_pkg::ATCC_K_RSVD;
      endcase
   endfunction : kind_of

   // Oscillator edge and holding registers
   logic       osc_rise, src_tick;
   logic [4:0] hold_wr, busy, load;
   logic [7:0] held [5];
   logic [7:0] dest [5];
   logic       async_r;

   atcc_sync u_osc (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .pin_in   (osc_in_pin_in),
      .rise_out (osc_rise)
   );

   // Source tick is every system cycle until async select is set
   assign src_tick = async_r ? osc_rise : 1'b1;

   for (genvar i = 0; i < 5; i++) begin : g_hold
      assign hold_wr[i] = bus_in.wr && (bus_in.addr == hold_ofs(i));
      atcc_hold #(.WIDTH(8)) u_hold (
         .clk_in   (clk_in),
         .reset_in (reset_in),
         .wr_in    (hold_wr[i]),
         .data_in  (bus_in.wdata),
         .edge_in  (src_tick),
         .busy_out (busy[i]),
         .load_out (load[i]),
         .held_out (held[i]),
         .dest_out (dest[i])
      );
   end

   // Decoded configuration
   logic [7:0] ctrl_a, ctrl_b, cmp_a, top;
   logic [1:0] oma;
   logic [2:0] wave;
   atcc_pkg::atcc_kind_t kind;
   assign ctrl_b = dest[0] & `ATCC_CTRL_B_MASK;
   assign ctrl_a = dest[1] & `ATCC_CTRL_A_MASK;
   assign cmp_a  = dest[3];
   assign oma    = ctrl_a[`ATCC_CA_OMA_HI:`ATCC_CA_OMA_LO];
   assign wave   = {ctrl_b[`ATCC_CB_WAVE_HI], ctrl_a[1:0]};
   assign kind   = kind_of(wave);
   assign top    = (wave == 3'h5 || wave == 3'h7 || wave == 3'h2) ? cmp_a : `ATCC_MAX;

   // Timer core state
   logic [9:0] presc_r, presc_nxt;
   logic [7:0] cnt_r, cnt_nxt, copy_r, copy_nxt;
   logic       up_r, up_nxt, oc_r, oc_nxt;
   logic       tick, match, ovf_ev, cmp_ev, psr_wr, at_top;

   assign psr_wr = bus_in.wr && bus_in.addr == `ATCC_OFS_GTC && bus_in.wdata[`ATCC_GTC_PSR];
   assign tick   = src_tick && tap_hit(ctrl_b[`ATCC_CB_CS_HI:0], presc_r);
   assign at_top = cnt_r == top;
   // Pending counter or compare A write blocks matching
   assign match  = tick && cnt_r == cmp_a && !busy[4] && !busy[3];
   assign cmp_ev = match;

   always_comb begin
      presc_nxt = presc_r;
      cnt_nxt   = cnt_r;
      up_nxt    = up_r;
      oc_nxt    = oc_r;
      copy_nxt  = copy_r;
      ovf_ev    = 1'b0;
      if (psr_wr) begin
         presc_nxt = 10'h000;
      end else if (src_tick) begin
         presc_nxt = presc_r + 10'h001;
      end
      if (tick) begin
         unique case (kind)
            atcc_pkg::ATCC_K_PC: begin
               if (up_r) begin
                  up_nxt  = !at_top;
                  cnt_nxt = at_top ? cnt_r - 8'h01 : cnt_r + 8'h01;
               end else begin
                  up_nxt  = cnt_r == `ATCC_BOTTOM;
                  ovf_ev  = cnt_r == `ATCC_BOTTOM;
                  cnt_nxt = up_nxt ? cnt_r + 8'h01 : cnt_r - 8'h01;
               end
            end
            atcc_pkg::ATCC_K_CTC: begin
               cnt_nxt = (cnt_r == cmp_a) ? `ATCC_BOTTOM : cnt_r + 8'h01;
               ovf_ev  = cnt_r == `ATCC_MAX;
            end
            atcc_pkg::ATCC_K_FAST: begin
               cnt_nxt = at_top ? `ATCC_BOTTOM : cnt_r + 8'h01;
               ovf_ev  = at_top;
            end
            default: begin
               cnt_nxt = cnt_r + 8'h01;
               ovf_ev  = cnt_r == `ATCC_MAX;
            end
         endcase
         // Output follows the tick directly, no resynchronising stage
         unique case (kind)
            atcc_pkg::ATCC_K_FAST: begin
               if (oma == 2'h1) begin
                  if (match && wave[2]) oc_nxt = !oc_r;
               end else if (oma[1]) begin
                  if (at_top) begin
                     oc_nxt = !oma[0];
                  end else if (match && cmp_a != top) begin
                     oc_nxt = oma[0];
                  end
               end
            end
            atcc_pkg::ATCC_K_PC: begin
               if (oma == 2'h1) begin
                  if (match && wave[2]) oc_nxt = !oc_r;
               end else if (oma[1]) begin
                  if (cmp_a == top) begin
                     if (at_top && up_r) oc_nxt = !oma[0];
                  end else if (match) begin
                     oc_nxt = up_r ? oma[0] : !oma[0];
                  end
               end
            end
            default: begin
               if (match) begin
                  unique case (oma)
                     2'h0: oc_nxt = oc_r;
                     2'h1: oc_nxt = !oc_r;
                     2'h2: oc_nxt = 1'b0;
                     2'h3: oc_nxt = 1'b1;
                  endcase
               end
            end
         endcase
      end
      if (load[4]) begin
         cnt_nxt = held[4];
      end
      // In async mode the CPU copy is frozen while asleep, so it shows the old count after wake
      if (!async_r) begin
         copy_nxt = cnt_nxt;
      end else if (osc_rise && !sleep_in) begin
         copy_nxt = cnt_r;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         presc_r <= 10'h000;
         cnt_r   <= `ATCC_RESET_VAL;
         copy_r  <= `ATCC_RESET_VAL;
         up_r    <= 1'b1;
         oc_r    <= 1'b0;
      end else begin
         presc_r <= presc_nxt;
         cnt_r   <= cnt_nxt;
         copy_r  <= copy_nxt;
         up_r    <= up_nxt;
         oc_r    <= oc_nxt;
      end
   end

   // Flag crossing, register port and pins
   logic [`ATCC_FLAG_SYNC-1:0] ovf_pipe_r, ovf_pipe_nxt, cmp_pipe_r, cmp_pipe_nxt;
   logic [1:0] flags_r, flags_nxt, flag_set;
   logic [7:0] rdata_r, rdata_nxt;
   logic       async_nxt;
   atcc_pkg::atcc_pins_t pins_r, pins_nxt;

   always_comb begin
      ovf_pipe_nxt = {ovf_pipe_r[`ATCC_FLAG_SYNC-2:0], ovf_ev};
      cmp_pipe_nxt = {cmp_pipe_r[`ATCC_FLAG_SYNC-2:0], cmp_ev};
      // Async flags ride a three-cycle pipe behind the tick
      flag_set  = async_r ? {cmp_pipe_r[`ATCC_FLAG_SYNC-1], ovf_pipe_r[`ATCC_FLAG_SYNC-1]}
                          : {cmp_ev, ovf_ev};
      flags_nxt = flags_r;
      async_nxt = async_r;
      rdata_nxt = `ATCC_RESET_VAL;
      if (bus_in.wr && bus_in.addr == `ATCC_OFS_FLAGS) begin
         flags_nxt = flags_r & ~bus_in.wdata[1:0];
      end
      flags_nxt = flags_nxt | flag_set;
      if (bus_in.wr && bus_in.addr == `ATCC_OFS_STATUS) begin
         async_nxt = bus_in.wdata[`ATCC_ST_ASYNC];
      end
      if (bus_in.rd) begin
         unique case (bus_in.addr)
            `ATCC_OFS_CTRL_A: rdata_nxt = ctrl_a;
            `ATCC_OFS_CTRL_B: rdata_nxt = ctrl_b;
            `ATCC_OFS_COUNT:  rdata_nxt = copy_r;
            `ATCC_OFS_CMP_A:  rdata_nxt = dest[3];
            `ATCC_OFS_CMP_B:  rdata_nxt = dest[2];
            `ATCC_OFS_STATUS: rdata_nxt = {2'h0, async_r, busy};
            `ATCC_OFS_FLAGS:  rdata_nxt = {6'h00, flags_r};
            default:          rdata_nxt = `ATCC_RESET_VAL;
         endcase
      end
      pins_nxt.oc          = oc_nxt;
      pins_nxt.oc_override = |oma;
      pins_nxt.port_disc   = async_nxt;
      pins_nxt.osc_en      = async_nxt && !deep_sleep_in;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ovf_pipe_r <= '0;
         cmp_pipe_r <= '0;
         flags_r    <= 2'h0;
         async_r    <= 1'b0;
         rdata_r    <= `ATCC_RESET_VAL;
         pins_r     <= '0;
      end else begin
         ovf_pipe_r <= ovf_pipe_nxt;
         cmp_pipe_r <= cmp_pipe_nxt;
         flags_r    <= flags_nxt;
         async_r    <= async_nxt;
         rdata_r    <= rdata_nxt;
         pins_r     <= pins_nxt;
      end
   end

   // Wake sequencing
   atcc_pkg::atcc_wake_t wk_r, wk_nxt;
   logic [2:0] halt_cnt_r, halt_cnt_nxt;
   logic       wake_r, wake_nxt, halt_r, halt_nxt;

   always_comb begin
      wk_nxt       = wk_r;
      halt_cnt_nxt = halt_cnt_r;
      wake_nxt     = 1'b0;
      halt_nxt     = 1'b0;
      unique case (wk_r)
         atcc_pkg::ATCC_WK_IDLE: begin
            if (sleep_in && |flag_set) wk_nxt = atcc_pkg::ATCC_WK_WAIT;
         end
         atcc_pkg::ATCC_WK_WAIT: begin
            // Waiting one tick guarantees the counter has moved on
            if (tick) begin
               wk_nxt       = atcc_pkg::ATCC_WK_HOLD;
               wake_nxt     = 1'b1;
               halt_nxt     = 1'b1;
               halt_cnt_nxt = `ATCC_WAKE_HOLD - 3'h1;
            end
         end
         atcc_pkg::ATCC_WK_HOLD: begin
            if (halt_cnt_r == 3'h0) begin
               wk_nxt = atcc_pkg::ATCC_WK_IDLE;
            end else begin
               halt_nxt     = 1'b1;
               halt_cnt_nxt = halt_cnt_r - 3'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wk_r       <= atcc_pkg::ATCC_WK_IDLE;
         halt_cnt_r <= 3'h0;
         wake_r     <= 1'b0;
         halt_r     <= 1'b0;
      end else begin
         wk_r       <= wk_nxt;
         halt_cnt_r <= halt_cnt_nxt;
         wake_r     <= wake_nxt;
         halt_r     <= halt_nxt;
      end
   end

   assign rdata_out    = rdata_r;
   assign pins_out     = pins_r;
   assign wake_out     = wake_r;
   assign cpu_halt_out = halt_r;

   a_match_while_busy: assert property (@(posedge clk_in) disable iff (reset_in)
      (busy[4] || busy[3]) |-> !cmp_ev) else $error("match during pending write");
   a_flag_sync_delay: assert property (@(posedge clk_in) disable iff (reset_in)
      (async_r && cmp_ev) ##1 async_r[*3] |=> flags_r[`ATCC_FL_CMPA])
      else $error("compare flag late");
   a_halt_four_cycles: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(cpu_halt_out) |-> cpu_halt_out[*4] ##1 !cpu_halt_out)
      else $error("halt length wrong");
   a_wake_on_tick: assert property (@(posedge clk_in) disable iff (reset_in)
      wake_out |-> $past(tick)) else $error("wake not on tick");
   a_oc_toggle_match: assert property (@(posedge clk_in) disable iff (reset_in)
      (match && kind == atcc_pkg::ATCC_K_NORMAL && oma == 2'h1 && !load[4])
      |=> pins_out.oc != $past(oc_r)) else $error("toggle missed");
   a_pc_up_clear: assert property (@(posedge clk_in) disable iff (reset_in)
      (match && kind == atcc_pkg::ATCC_K_PC && oma == 2'h2 && up_r && cmp_a != top)
      |=> !pins_out.oc) else $error("up match did not clear");
   a_presc_reset: assert property (@(posedge clk_in) disable iff (reset_in)
      psr_wr |=> presc_r == 10'h000) else $error("prescaler not reset");
   a_override_pin: assert property (@(posedge clk_in) disable iff (reset_in)
      (|oma) |=> pins_out.oc_override) else $error("override missing");
   a_osc_power_down: assert property (@(posedge clk_in) disable iff (reset_in)
      deep_sleep_in |=> !pins_out.osc_en) else $error("oscillator left on");
   a_copy_frozen: assert property (@(posedge clk_in) disable iff (reset_in)
      (async_r && $past(async_r) && !$past(osc_rise)) |-> $stable(copy_r))
      else $error("copy moved without edge");
   c_async_transfer: cover property (@(posedge clk_in) disable iff (reset_in)
      async_r && hold_wr[3] ##[1:200] load[3]);
   c_fast_pwm_bottom: cover property (@(posedge clk_in) disable iff (reset_in)
      tick && kind == atcc_pkg::ATCC_K_FAST && at_top && oma[1]);
   c_wake_sequence: cover property (@(posedge clk_in) disable iff (reset_in)
      wake_out ##4 !cpu_halt_out);
endmodule : atcc_timer

// file: hw/atcc_params.svh
// Offsets, field positions, reset values and timing counts of the async timer
`ifndef ATCC_PARAMS_SVH
`define ATCC_PARAMS_SVH

`define ATCC_OFS_CTRL_A    8'hB0
`define ATCC_OFS_CTRL_B    8'hB1
`define ATCC_OFS_COUNT     8'hB2
`define ATCC_OFS_CMP_A     8'hB3
`define ATCC_OFS_CMP_B     8'hB4
`define ATCC_OFS_STATUS    8'hB6
`define ATCC_OFS_FLAGS     8'hB7
`define ATCC_OFS_GTC       8'hB8

`define ATCC_RESET_VAL     8'h00
`define ATCC_CTRL_A_MASK   8'hF3
`define ATCC_CTRL_B_MASK   8'h0F
`define ATCC_MAX           8'hFF
`define ATCC_BOTTOM        8'h00

`define ATCC_CA_OMA_HI     7
`define ATCC_CA_OMA_LO     6
`define ATCC_CB_WAVE_HI    3
`define ATCC_CB_CS_HI      2
`define ATCC_ST_ASYNC      5
`define ATCC_FL_OVF        0
`define ATCC_FL_CMPA       1
`define ATCC_GTC_PSR       1

`define ATCC_HOLD_EDGES    2'h2
`define ATCC_FLAG_SYNC     3
`define ATCC_WAKE_HOLD     3'h4

`endif

// file: hw/atcc_pkg.sv
// Types shared by the async timer block
package atcc_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } atcc_bus_t;

   typedef struct packed {
      logic oc;
      logic oc_override;
      logic port_disc;
      logic osc_en;
   } atcc_pins_t;

   typedef enum logic [2:0] {
      ATCC_K_NORMAL,
      ATCC_K_PC,
      ATCC_K_CTC,
      ATCC_K_FAST,
      ATCC_K_RSVD
   } atcc_kind_t;

   typedef enum logic [1:0] {
      ATCC_WK_IDLE,
      ATCC_WK_WAIT,
      ATCC_WK_HOLD
   } atcc_wake_t;
endpackage : atcc_pkg

// file: hw/atcc_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
module atcc_sync (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic reset_in,
   // Pin and result
   input  wire logic pin_in,
   output logic      rise_out
);
   logic s1_r, s2_r, s3_r, lvl_r, rise_r;
   logic lvl_nxt, rise_nxt;

   // Edge is only seen reliably while the system clock is well above the pin rate
   always_comb begin
      lvl_nxt  = (s2_r == s3_r) ? s3_r : lvl_r;
      rise_nxt = lvl_nxt & ~lvl_r;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s1_r   <= 1'b0;
         s2_r   <= 1'b0;
         s3_r   <= 1'b0;
         lvl_r  <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         s1_r   <= pin_in;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         lvl_r  <= lvl_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign rise_out = rise_r;
endmodule : atcc_sync

// file: hw/atcc_hold.sv
// Holding register that moves a written value after two source edges
`include "atcc_params.svh"
module atcc_hold #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // Write side
   input  wire logic             wr_in,
   input  wire logic [WIDTH-1:0] data_in,
   input  wire logic             edge_in,
   // Status and destination
   output logic                  busy_out,
   output logic                  load_out,
   output logic [WIDTH-1:0]      held_out,
   output logic [WIDTH-1:0]      dest_out
);
   logic [1:0]       count_r, count_nxt;
   logic             busy_r, busy_nxt, load_r, load_nxt;
   logic [WIDTH-1:0] held_r, held_nxt, dest_r, dest_nxt;

   always_comb begin
      count_nxt = count_r;
      busy_nxt  = busy_r;
      held_nxt  = held_r;
      dest_nxt  = dest_r;
      load_nxt  = 1'b0;
      if (wr_in) begin
         // A fresh write restarts the transfer
         held_nxt  = data_in;
         busy_nxt  = 1'b1;
         count_nxt = 2'h0;
      end else if (busy_r && edge_in) begin
         if (count_r == `ATCC_HOLD_EDGES - 2'h1) begin
            busy_nxt = 1'b0;
            load_nxt = 1'b1;
            dest_nxt = held_r;
         end else begin
            count_nxt = count_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count_r <= 2'h0;
         busy_r  <= 1'b0;
         load_r  <= 1'b0;
         held_r  <= '0;
         dest_r  <= '0;
      end else begin
         count_r <= count_nxt;
         busy_r  <= busy_nxt;
         load_r  <= load_nxt;
         held_r  <= held_nxt;
         dest_r  <= dest_nxt;
      end
   end

   assign busy_out = busy_r;
   assign load_out = load_r;
   assign held_out = held_r;
   assign dest_out = dest_r;

   a_hold_write_busy: assert property (@(posedge clk_in) disable iff (reset_in)
      wr_in |=> busy_out) else $error("busy not set after write");
   a_hold_two_edges: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(busy_out) ##0 (!edge_in && !wr_in)[*2] |=> !load_out)
      else $error("transfer before two edges");
   c_hold_transfer: cover property (@(posedge clk_in) disable iff (reset_in)
      $rose(busy_out) ##[1:50] load_out);
endmodule : atcc_hold

// file: test/atcc_timer_bench.sv
// Self-checking bench for the async timer block
module atcc_timer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clk_in = 1'b0;
   logic                 reset_in = 1'b1;
   atcc_pkg::atcc_bus_t  bus = '0;
   logic [7:0]           rdata;
   logic                 osc = 1'b0;
   logic                 sleep = 1'b0;
   logic                 deep = 1'b0;
   atcc_pkg::atcc_pins_t pins;
   logic                 wake;
   logic                 halt;
   int                   fails = 0;
   int                   n_compared = 0;
   int                   wake_cnt = 0;
   int                   halt_cnt = 0;
   logic                 o;
   int                   hi = 0;

   always #2 clk_in = ~clk_in;

   atcc_timer u_atcc_timer (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .bus_in        (bus),
      .rdata_out     (rdata),
      .osc_in_pin_in (osc),
      .sleep_in      (sleep),
      .deep_sleep_in (deep),
      .pins_out      (pins),
      .wake_out      (wake),
      .cpu_halt_out  (halt)
   );

   // Wake pulses and halt cycles, counted for the whole run
   always @(posedge clk_in) begin
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
      if (halt === 1'b1) halt_cnt <= halt_cnt + 1;
   end

   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Strobes stay up until the next op or idle, so ops can run back to back
   task op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: d, wr: w, rd: r};
   endtask : op

   task idle;
      @(posedge clk_in);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1;
   endtask : idle

   task wr(input logic [7:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
      idle();
   endtask : wr

   task rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
      op(1'b0, 1'b1, a, 8'h00);
      idle();
      chk(what, rdata, exp);
   endtask : rdc

   // One oscillator period, far slower than the system clock
   task tick;
      repeat (8) @(posedge clk_in);
      osc <= 1'b1;
      repeat (8) @(posedge clk_in);
      osc <= 1'b0;
   endtask : tick

   task wait_chk_oc(input int n, input logic exp);
      repeat (n) @(posedge clk_in);
      #1;
      chk("oc", {7'h00, pins.oc}, {7'h00, exp});
   endtask : wait_chk_oc

   initial begin
      repeat (10) @(posedge clk_in);
      reset_in <= 1'b0;
      rdc(8'hB0, 8'h00, "ctrl_a reset");
      rdc(8'hB6, 8'h00, "status reset");
      op(1'b1, 1'b0, 8'hB0, 8'hFF);
      rdc(8'hB6, 8'h02, "ctrl_a busy");
      rdc(8'hB6, 8'h00, "busy clear");
      rdc(8'hB0, 8'hF3, "ctrl_a");
      rdc(8'hB5, 8'h00, "unmapped");
      wr(8'hB8, 8'h02);
      rdc(8'hB8, 8'h00, "gen ctrl");
      $display("test registers done");
      wr(8'hB3, 8'h80);
      wr(8'hB1, 8'h01);
      for (int m = 1; m < 4; m++) begin
         wr(8'hB0, 8'(m << 6));
         repeat (8) @(posedge clk_in);
         #1;
         chk("override", {7'h00, pins.oc_override}, 8'h01);
         o = pins.oc;
         wait_chk_oc(m == 1 ? 256 : 300, m == 1 ? ~o : m == 3);
      end
      wr(8'hB0, 8'h43);
      repeat (8) @(posedge clk_in);
      #1;
      o = pins.oc;
      wait_chk_oc(300, o);
      // Non-inverting fast PWM: high from bottom through the match, 129 of 256 cycles
      wr(8'hB0, 8'h83);
      repeat (300) @(posedge clk_in);
      for (int k = 0; k < 256; k++) begin
         @(posedge clk_in);
         #1;
         hi = hi + int'(pins.oc);
      end
      chk("pwm high", 8'(hi), 8'h81);
      wr(8'hB0, 8'h00);
      repeat (8) @(posedge clk_in);
      #1;
      chk("override off", {7'h00, pins.oc_override}, 8'h00);
      $display("test compare output done");
      wr(8'hB6, 8'h20);
      repeat (4) @(posedge clk_in);
      chk("port disc", {7'h00, pins.port_disc}, 8'h01);
      chk("osc en", {7'h00, pins.osc_en}, 8'h01);
      deep <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk("osc deep", {7'h00, pins.osc_en}, 8'h00);
      deep <= 1'b0;
      wr(8'hB3, 8'h55);
      wr(8'hB2, 8'h10);
      wr(8'hB1, 8'h00);
      rdc(8'hB6, 8'h39, "busy set");
      tick();
      rdc(8'hB6, 8'h39, "busy one edge");
      tick();
      rdc(8'hB6, 8'h20, "busy done");
      rdc(8'hB3, 8'h55, "cmp a");
      tick();
      rdc(8'hB2, 8'h10, "count copy");
      $display("test async transfer done");
      wr(8'hB7, 8'hFF);
      wr(8'hB1, 8'h01);
      tick();
      tick();
      sleep <= 1'b1;
      for (int i = 0; i < 300 && wake_cnt == 0; i++) tick();
      repeat (8) @(posedge clk_in);
      sleep <= 1'b0;
      chk("wakes", 8'(wake_cnt), 8'h01);
      chk("halt", 8'(halt_cnt), 8'h04);
      rdc(8'hB7, 8'h02, "flags");
      $display("test wake done");
      print_verdict();
   end

   initial begin
      #200000;
      fails++;
      print_verdict();
   end
endmodule : atcc_timer_bench
